/* File: logic/pin_remap_pkg.sv */
package pin_remap_pkg;

  // Register byte offsets on the word-wide bus.
  localparam logic [4:0]  REMAP_OFFSET       = 5'h04;
  localparam logic [4:0]  IRQ_SEL_0_3_OFFSET = 5'h08;
  localparam logic [4:0]  IRQ_SEL_4_7_OFFSET = 5'h0C;
  localparam logic [4:0]  IRQ_SEL_8_11_OFFSET = 5'h10;

  // Reset values.
  localparam logic [31:0] REMAP_RESET        = 32'h00000000;
  localparam logic [15:0] IRQ_SEL_RESET      = 16'h0000;

  // Stored, readable bits of the remap register; everything else reads zero.
  localparam logic [31:0] REMAP_RW_MASK      = 32'h00009FFF;

  // Field positions in the remap register.
  localparam int DEBUG_CFG_LSB    = 24;
  localparam int DEBUG_CFG_MSB    = 26;
  localparam int OSC_REMAP_BIT    = 15;
  localparam int TIMER4_BIT       = 12;
  localparam int TIMER3_LSB       = 10;
  localparam int TIMER2_LSB       = 8;
  localparam int TIMER1_LSB       = 6;
  localparam int SERIAL3_LSB      = 4;
  localparam int SERIAL2_BIT      = 3;
  localparam int SERIAL1_BIT      = 2;
  localparam int TWO_WIRE1_BIT    = 1;
  localparam int SPI1_BIT         = 0;

  // Interrupt source selector layout.
  localparam int IRQ_LINES        = 12;
  localparam int LINES_PER_REG    = 4;
  localparam int SEL_WIDTH        = 4;
  localparam int SEL_FIELD_BITS   = 16;

  // Debug port configuration codes.
  localparam logic [2:0] DEBUG_FULL        = 3'h0;
  localparam logic [2:0] DEBUG_NO_TRST     = 3'h1;
  localparam logic [2:0] DEBUG_SWD_ONLY    = 3'h2;
  localparam logic [2:0] DEBUG_OFF         = 3'h4;

  // Two-bit map codes shared by the timer 1 to 3 and serial 3 fields.
  localparam logic [1:0] MAP_DEFAULT      = 2'h0;
  localparam logic [1:0] MAP_PARTIAL_LOW  = 2'h1;
  localparam logic [1:0] MAP_PARTIAL_HIGH = 2'h2;
  localparam logic [1:0] MAP_FULL         = 2'h3;

  // Port indices for selector codes 0000 to 0110.
  localparam int NUM_PORTS = 7;
  localparam int PORT_A = 0;
  localparam int PORT_B = 1;
  localparam int PORT_C = 2;
  localparam int PORT_D = 3;
  localparam int PORT_E = 4;
  localparam int PINS_PER_PORT = 16;

endpackage

/* File: logic/pin_remap.sv */
// Register access over Avalon-MM was decided locally.
`timescale 1ns/10ps
module pin_remap
  import pin_remap_pkg::*;
(
  input  wire logic        mclk_i,                 // Bus clock, 20 MHz.
  input  wire logic        rstn_i,                 // Asynchronous reset, active low.
  input  wire logic [4:0]  avs_address_i,          // Byte address.
  input  wire logic        avs_read_i,             // Read request.
  input  wire logic        avs_write_i,            // Write request.
  input  wire logic [31:0] avs_writedata_i,        // Write data.
  input  wire logic [3:0]  avs_byteenable_i,       // Byte lanes.
  output logic      [31:0] avs_readdata_o,         // Read data.
  output logic             avs_waitrequest_o,      // Stall while high.
  input  wire logic [15:0] port_a_pins_i,          // Port A pin levels.
  input  wire logic [15:0] port_b_pins_i,          // Port B pin levels.
  input  wire logic [15:0] port_c_pins_i,          // Port C pin levels.
  input  wire logic [15:0] port_d_pins_i,          // Port D pin levels.
  input  wire logic [15:0] port_e_pins_i,          // Port E pin levels.
  input  wire logic [15:0] port_f_pins_i,          // Port F pin levels.
  input  wire logic [15:0] port_g_pins_i,          // Port G pin levels.
  output logic [pin_remap_pkg::IRQ_LINES-1:0] ext_irq_line_source_o, // Level per line.
  output logic             debug_jtag_en_o,        // JTAG debug port enabled.
  output logic             debug_swd_en_o,         // Two-wire debug port enabled.
  output logic             debug_test_reset_pin_en_o, // Test-reset pin owned by debug.
  output logic             port_d_low_pins_to_osc_o, // D0/D1 on oscillator pins.
  output logic             timer4_pin_swap_o,      // Timer 4 channels on D12-D15.
  output logic [1:0]       timer3_pin_swap_o,      // Timer 3 map code.
  output logic [1:0]       timer2_pin_swap_o,      // Timer 2 map code.
  output logic [1:0]       timer1_pin_swap_o,      // Timer 1 map code.
  output logic [1:0]       serial3_pin_swap_o,     // Serial 3 map code.
  output logic             serial2_pin_swap_o,     // Serial 2 on port D.
  output logic             serial1_pin_swap_o,     // Serial 1 on B6/B7.
  output logic             two_wire1_pin_swap_o,   // Two-wire 1 on B8/B9.
  output logic             spi_port1_pin_swap_o,   // SPI 1 on A15/B3-B5.
  output logic             timer34_external_trigger_input_o, // Timer 3/4 trigger level.
  output logic             timer2_external_trigger_input_o,  // Timer 2 trigger level.
  output logic             timer1_external_trigger_input_o,  // Timer 1 trigger level.
  output logic             timer1_break_input_o,   // Timer 1 break level.
  output logic             serial1_rx_o,           // Serial 1 receive level.
  output logic             serial2_rx_o,           // Serial 2 receive level.
  output logic             serial3_rx_o,           // Serial 3 receive level.
  output logic             spi_port1_miso_o        // SPI 1 master-in level.
);

  import pin_remap_pkg::*;

  typedef logic [NUM_PORTS-1:0][PINS_PER_PORT-1:0] pin_array_t;

  // Pin synchronisers: the first stage feeds only the second.
  pin_array_t raw_pins;
  pin_array_t sync1;
  pin_array_t sync2;
  pin_array_t sync3;
  pin_array_t pins;

  assign raw_pins = {port_g_pins_i, port_f_pins_i, port_e_pins_i, port_d_pins_i,
                     port_c_pins_i, port_b_pins_i, port_a_pins_i};

  // A level is accepted only once the second and third stages agree, which
  // filters a single-cycle disagreement at the cost of one more cycle of delay.
  wire pin_array_t agree_pins = ~(sync2 ^ sync3);
  wire pin_array_t next_pins  = (agree_pins & sync3) | (~agree_pins & pins);

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      pins  <= '0;
    end
    else
    begin
      sync1 <= raw_pins;
      sync2 <= sync1;
      sync3 <= sync2;
      pins  <= next_pins;
    end
  end

  function automatic logic pin_at(input pin_array_t arr, input int port, input int idx);
    pin_at = arr[port][idx];
  endfunction

  // Bus slave with one wait state on every access.
  logic        ack;
  logic [31:0] remap;
  logic [2:0]  debug_cfg;
  logic [IRQ_LINES*SEL_WIDTH-1:0] irq_sel;

  wire logic req        = avs_read_i | avs_write_i;
  wire logic full_word  = (avs_byteenable_i == 4'hF);
  wire logic hit_remap  = (avs_address_i == REMAP_OFFSET);
  wire logic hit_sel0   = (avs_address_i == IRQ_SEL_0_3_OFFSET);
  wire logic hit_sel1   = (avs_address_i == IRQ_SEL_4_7_OFFSET);
  wire logic hit_sel2   = (avs_address_i == IRQ_SEL_8_11_OFFSET);
  // Partial-word writes are dropped; software only issues whole words.
  wire logic wr_take    = avs_write_i & ~ack & full_word;
  wire logic [2:0] wr_debug = avs_writedata_i[DEBUG_CFG_MSB:DEBUG_CFG_LSB];
  wire logic debug_code_ok = (wr_debug == DEBUG_FULL) || (wr_debug == DEBUG_NO_TRST) ||
                             (wr_debug == DEBUG_SWD_ONLY) || (wr_debug == DEBUG_OFF);
  wire logic [31:0] next_remap = (avs_writedata_i & REMAP_RW_MASK) |
                                 (remap & ~REMAP_RW_MASK);

  assign avs_waitrequest_o = req & ~ack;

  // Debug configuration reads back as zero; its stored value shows only on the debug enable outputs.
  wire logic [31:0] rd_mux =
    hit_remap ? (remap & REMAP_RW_MASK) :
    hit_sel0  ? {16'h0000, irq_sel[0*SEL_FIELD_BITS +: SEL_FIELD_BITS]} :
    hit_sel1  ? {16'h0000, irq_sel[1*SEL_FIELD_BITS +: SEL_FIELD_BITS]} :
    hit_sel2  ? {16'h0000, irq_sel[2*SEL_FIELD_BITS +: SEL_FIELD_BITS]} :
    32'h00000000;

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ack            <= 1'b0;
      avs_readdata_o <= 32'h00000000;
    end
    else
    begin
      ack <= req & ~ack;
      if (avs_read_i && !ack)
      begin
        avs_readdata_o <= rd_mux;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      remap     <= REMAP_RESET & REMAP_RW_MASK;
      debug_cfg <= DEBUG_FULL;
    end
    else if (wr_take && hit_remap)
    begin
      remap <= next_remap;
      if (debug_code_ok)
      begin
        debug_cfg <= wr_debug;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < IRQ_LINES / LINES_PER_REG; g++)
    begin : g_sel_reg
      wire logic hit = (g == 0) ? hit_sel0 : (g == 1) ? hit_sel1 : hit_sel2;
      always_ff @(posedge mclk_i or negedge rstn_i)
      begin
        if (!rstn_i)
        begin
          irq_sel[g*SEL_FIELD_BITS +: SEL_FIELD_BITS] <= IRQ_SEL_RESET;
        end
        else if (wr_take && hit)
        begin
          irq_sel[g*SEL_FIELD_BITS +: SEL_FIELD_BITS] <=
            avs_writedata_i[SEL_FIELD_BITS-1:0];
        end
      end
    end
  endgenerate

  // Interrupt line sources; selector codes beyond port G give a low level.
  generate
    for (g = 0; g < IRQ_LINES; g++)
    begin : g_irq
      wire logic [SEL_WIDTH-1:0] sel = irq_sel[g*SEL_WIDTH +: SEL_WIDTH];
      wire logic src = (sel < SEL_WIDTH'(NUM_PORTS)) ?
                       pins[sel[2:0]][g] : 1'b0;
      always_ff @(posedge mclk_i or negedge rstn_i)
      begin
        if (!rstn_i)
        begin
          ext_irq_line_source_o[g] <= 1'b0;
        end
        else
        begin
          ext_irq_line_source_o[g] <= src;
        end
      end
    end
  endgenerate

  // Remap fields; unused codes are passed through and treated as default below.
  assign port_d_low_pins_to_osc_o = remap[OSC_REMAP_BIT];
  assign timer4_pin_swap_o    = remap[TIMER4_BIT];
  assign timer3_pin_swap_o    = remap[TIMER3_LSB +: 2];
  assign timer2_pin_swap_o    = remap[TIMER2_LSB +: 2];
  assign timer1_pin_swap_o    = remap[TIMER1_LSB +: 2];
  assign serial3_pin_swap_o   = remap[SERIAL3_LSB +: 2];
  assign serial2_pin_swap_o   = remap[SERIAL2_BIT];
  assign serial1_pin_swap_o   = remap[SERIAL1_BIT];
  assign two_wire1_pin_swap_o = remap[TWO_WIRE1_BIT];
  assign spi_port1_pin_swap_o = remap[SPI1_BIT];

  // Debug port enables follow the accepted configuration code.
  wire logic next_jtag_en = (debug_cfg == DEBUG_FULL) || (debug_cfg == DEBUG_NO_TRST);
  wire logic next_swd_en  = (debug_cfg != DEBUG_OFF);
  wire logic next_trst_en = (debug_cfg == DEBUG_FULL);

  // Input-direction alternate functions gathered from the selected pin.
  wire logic next_t34_trig = pin_at(pins, PORT_E, 0);
  wire logic next_t2_trig  = remap[TIMER2_LSB] ? pin_at(pins, PORT_A, 15)
                                               : pin_at(pins, PORT_A, 0);
  wire logic t1_full       = (remap[TIMER1_LSB +: 2] == MAP_FULL);
  wire logic t1_partial    = (remap[TIMER1_LSB +: 2] == MAP_PARTIAL_LOW);
  wire logic next_t1_trig  = t1_full ? pin_at(pins, PORT_E, 7)
                                     : pin_at(pins, PORT_A, 12);
  wire logic next_t1_brk   = t1_full    ? pin_at(pins, PORT_E, 15) :
                             t1_partial ? pin_at(pins, PORT_A, 6)  :
                                          pin_at(pins, PORT_B, 12);
  wire logic next_s1_rx    = remap[SERIAL1_BIT] ? pin_at(pins, PORT_B, 7)
                                                : pin_at(pins, PORT_A, 10);
  wire logic next_s2_rx    = remap[SERIAL2_BIT] ? pin_at(pins, PORT_D, 6)
                                                : pin_at(pins, PORT_A, 3);
  wire logic [1:0] s3_map  = remap[SERIAL3_LSB +: 2];
  wire logic next_s3_rx    = (s3_map == MAP_FULL)        ? pin_at(pins, PORT_D, 9)  :
                             (s3_map == MAP_PARTIAL_LOW) ? pin_at(pins, PORT_C, 11) :
                                                           pin_at(pins, PORT_B, 11);
  wire logic next_miso     = remap[SPI1_BIT] ? pin_at(pins, PORT_B, 4)
                                             : pin_at(pins, PORT_A, 6);

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      debug_jtag_en_o                  <= 1'b1;
      debug_swd_en_o                   <= 1'b1;
      debug_test_reset_pin_en_o        <= 1'b1;
      timer34_external_trigger_input_o <= 1'b0;
      timer2_external_trigger_input_o  <= 1'b0;
      timer1_external_trigger_input_o  <= 1'b0;
      timer1_break_input_o             <= 1'b0;
      serial1_rx_o                     <= 1'b0;
      serial2_rx_o                     <= 1'b0;
      serial3_rx_o                     <= 1'b0;
      spi_port1_miso_o                 <= 1'b0;
    end
    else
    begin
      debug_jtag_en_o                  <= next_jtag_en;
      debug_swd_en_o                   <= next_swd_en;
      debug_test_reset_pin_en_o        <= next_trst_en;
      timer34_external_trigger_input_o <= next_t34_trig;
      timer2_external_trigger_input_o  <= next_t2_trig;
      timer1_external_trigger_input_o  <= next_t1_trig;
      timer1_break_input_o             <= next_t1_brk;
      serial1_rx_o                     <= next_s1_rx;
      serial2_rx_o                     <= next_s2_rx;
      serial3_rx_o                     <= next_s3_rx;
      spi_port1_miso_o                 <= next_miso;
    end
  end

endmodule // pin_remap

/* File: sim/pin_remap_checker.sv */
`timescale 1ns/10ps
module pin_remap_checker
  import pin_remap_pkg::*;
(
  input wire logic        mclk_i,                    // Clock.
  input wire logic        rstn_i,                    // Reset, low.
  input wire logic [4:0]  avs_address_i,             // Address.
  input wire logic        avs_read_i,                // Read.
  input wire logic        avs_write_i,               // Write.
  input wire logic [31:0] avs_writedata_i,           // Data in.
  input wire logic [3:0]  avs_byteenable_i,          // Lanes.
  input wire logic [31:0] avs_readdata_o,            // Data out.
  input wire logic        avs_waitrequest_o,         // Stall.
  input wire logic        debug_jtag_en_o,           // JTAG on.
  input wire logic        debug_swd_en_o,            // Two-wire debug on.
  input wire logic        debug_test_reset_pin_en_o, // Test reset on.
  input wire logic        port_d_low_pins_to_osc_o,  // Osc remap.
  input wire logic        timer4_pin_swap_o,         // Timer 4.
  input wire logic [1:0]  timer3_pin_swap_o,         // Timer 3.
  input wire logic [1:0]  timer2_pin_swap_o,         // Timer 2.
  input wire logic [1:0]  timer1_pin_swap_o,         // Timer 1.
  input wire logic [1:0]  serial3_pin_swap_o,        // Serial 3.
  input wire logic        serial2_pin_swap_o,        // Serial 2.
  input wire logic        serial1_pin_swap_o,        // Serial 1.
  input wire logic        two_wire1_pin_swap_o,      // Two-wire 1.
  input wire logic        spi_port1_pin_swap_o       // SPI 1.
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  wire logic       rd_done  = avs_read_i && !avs_waitrequest_o;
  wire logic       wr_remap = avs_write_i && !avs_waitrequest_o
                              && avs_address_i == REMAP_OFFSET && avs_byteenable_i == 4'hF;
  wire logic [2:0] code     = avs_writedata_i[DEBUG_CFG_MSB:DEBUG_CFG_LSB];
  wire logic       code_ok  = code inside {DEBUG_FULL, DEBUG_NO_TRST, DEBUG_SWD_ONLY, DEBUG_OFF};
  wire logic [2:0] dbg      = {debug_jtag_en_o, debug_swd_en_o, debug_test_reset_pin_en_o};
  wire logic [2:0] dbg_exp  = code == DEBUG_FULL ? 3'h7 : code == DEBUG_NO_TRST ? 3'h6 :
                              code == DEBUG_SWD_ONLY ? 3'h2 : 3'h0;
  wire logic       is_sel   = avs_address_i inside {IRQ_SEL_0_3_OFFSET, IRQ_SEL_4_7_OFFSET,
                                                    IRQ_SEL_8_11_OFFSET};
  wire logic       mapped   = is_sel || avs_address_i == REMAP_OFFSET;

  a_one_wait: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("bus answer not after one wait state");
  a_idle_nowait: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
    else $error("wait raised without a request");
  a_remap_read_mask: assert property (rd_done && avs_address_i == REMAP_OFFSET
    |-> (avs_readdata_o & 32'hFFFF6000) == 32'h0) else $error("remap read shows hidden bits");
  a_select_upper_zero: assert property (rd_done && is_sel
    |-> avs_readdata_o[31:16] == 16'h0) else $error("selector upper half not zero");
  a_unmapped_zero: assert property (rd_done && !mapped |-> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_remap_bits: assert property (wr_remap |->
    {port_d_low_pins_to_osc_o, timer4_pin_swap_o, timer3_pin_swap_o, timer2_pin_swap_o,
     timer1_pin_swap_o, serial3_pin_swap_o, serial2_pin_swap_o, serial1_pin_swap_o,
     two_wire1_pin_swap_o, spi_port1_pin_swap_o} == {avs_writedata_i[15], avs_writedata_i[12:0]})
    else $error("remap outputs differ from written bits");
  a_debug_codes: assert property (wr_remap && code_ok |=> dbg == $past(dbg_exp))
    else $error("debug enables wrong for code");
  a_debug_hold: assert property (wr_remap && !code_ok |=> $stable(dbg))
    else $error("debug enables moved on unused code");

  c_debug_off: cover property (wr_remap && code == DEBUG_OFF);
  c_bad_code: cover property (wr_remap && !code_ok);
  c_unmapped: cover property (rd_done && !mapped);
endmodule // pin_remap_checker

bind pin_remap pin_remap_checker u_chk (.mclk_i, .rstn_i, .avs_address_i, .avs_read_i,
  .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
  .debug_jtag_en_o, .debug_swd_en_o, .debug_test_reset_pin_en_o, .port_d_low_pins_to_osc_o,
  .timer4_pin_swap_o, .timer3_pin_swap_o, .timer2_pin_swap_o, .timer1_pin_swap_o,
  .serial3_pin_swap_o, .serial2_pin_swap_o, .serial1_pin_swap_o, .two_wire1_pin_swap_o,
  .spi_port1_pin_swap_o);

/* File: sim/pin_source_model.sv */
`timescale 1ns/10ps
module pin_source_model (
  input  wire logic        mclk_i,    // Clock.
  input  wire logic [15:0] base_i,    // Seed pattern.
  output logic      [15:0] pins_o [7] // Ports A to G.
);
  // Each port is scrambled differently so that a wrong port choice shows as a wrong level.
  always_ff @(posedge mclk_i)
  begin
    for (int k = 0; k < 7; k++)
    begin
      pins_o[k] <= base_i ^ (16'h6F4B * 16'(k + 3));
    end
  end
endmodule // pin_source_model

/* File: sim/testbench.sv */
`timescale 1ns/10ps
module testbench;
  import pin_remap_pkg::*;
  logic        mclk_i, rstn_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [4:0]  avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic [3:0]  avs_byteenable_i;
  logic [15:0] base;
  logic [15:0] pins [7];
  logic [IRQ_LINES-1:0] ext_irq_line_source_o;
  logic debug_jtag_en_o, debug_swd_en_o, debug_test_reset_pin_en_o, port_d_low_pins_to_osc_o;
  logic timer4_pin_swap_o, serial2_pin_swap_o, serial1_pin_swap_o, two_wire1_pin_swap_o;
  logic spi_port1_pin_swap_o, timer34_external_trigger_input_o, timer2_external_trigger_input_o;
  logic timer1_external_trigger_input_o, timer1_break_input_o, serial1_rx_o, serial2_rx_o;
  logic serial3_rx_o, spi_port1_miso_o;
  logic [1:0] timer3_pin_swap_o, timer2_pin_swap_o, timer1_pin_swap_o, serial3_pin_swap_o;
  int failures = 0;
  int checked = 0;

  pin_remap dut (.mclk_i, .rstn_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .port_a_pins_i(pins[0]),
    .port_b_pins_i(pins[1]), .port_c_pins_i(pins[2]), .port_d_pins_i(pins[3]),
    .port_e_pins_i(pins[4]), .port_f_pins_i(pins[5]), .port_g_pins_i(pins[6]),
    .ext_irq_line_source_o, .debug_jtag_en_o, .debug_swd_en_o, .debug_test_reset_pin_en_o,
    .port_d_low_pins_to_osc_o, .timer4_pin_swap_o, .timer3_pin_swap_o, .timer2_pin_swap_o,
    .timer1_pin_swap_o, .serial3_pin_swap_o, .serial2_pin_swap_o, .serial1_pin_swap_o,
    .two_wire1_pin_swap_o, .spi_port1_pin_swap_o, .timer34_external_trigger_input_o,
    .timer2_external_trigger_input_o, .timer1_external_trigger_input_o, .timer1_break_input_o,
    .serial1_rx_o, .serial2_rx_o, .serial3_rx_o, .spi_port1_miso_o);
  pin_source_model pin_src (.mclk_i, .base_i(base), .pins_o(pins));

  initial
  begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  task automatic summarize;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      failures++;
    end
  endtask

  // The request holds until waitrequest is sampled low at a rising edge; read data is taken there.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do
    begin
      @(posedge mclk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (n >= 20)
    begin
      failures++;
      summarize();
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask

  // Pin paths need five edges; eight leave margin for the model's own register.
  task automatic settle;
    repeat (8) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask

  task automatic reset_vals;
    rd(REMAP_OFFSET, 32'h0);
    rd(IRQ_SEL_0_3_OFFSET, 32'h0);
    rd(IRQ_SEL_4_7_OFFSET, 32'h0);
    rd(IRQ_SEL_8_11_OFFSET, 32'h0);
    rd(5'h14, 32'h0);
    chk({debug_jtag_en_o, debug_swd_en_o, debug_test_reset_pin_en_o}, 3'h7);
  endtask

  task automatic remap_fields;
    wr(REMAP_OFFSET, 32'hFFFFFFFF);
    rd(REMAP_OFFSET, 32'h00009FFF);
    avs_byteenable_i <= 4'h3;
    wr(REMAP_OFFSET, 32'h0);
    avs_byteenable_i <= 4'hF;
    rd(REMAP_OFFSET, 32'h00009FFF);
    chk(debug_jtag_en_o, 1'b1);
  endtask

  task automatic debug_codes;
    logic [2:0] code [6] = '{3'h1, 3'h2, 3'h4, 3'h3, 3'h7, 3'h0};
    logic [2:0] exp [6] = '{3'h6, 3'h2, 3'h0, 3'h0, 3'h0, 3'h7};
    for (int i = 0; i < 6; i++)
    begin
      wr(REMAP_OFFSET, {5'h0, code[i], 24'h0});
      settle();
      chk({debug_jtag_en_o, debug_swd_en_o, debug_test_reset_pin_en_o}, exp[i]);
      rd(REMAP_OFFSET, 32'h0);
    end
  endtask

  task automatic pin_mux;
    // The last map sets the unused timer 1 and serial 3 codes, which must act as default.
    logic [31:0] cfg [4] = '{32'h0, 32'h15D, 32'h9CF2, 32'hA0};
    logic [7:0] src [4][8] = '{'{8'h40, 8'h00, 8'h0C, 8'h1C, 8'h0A, 8'h03, 8'h1B, 8'h06},
                               '{8'h40, 8'h0F, 8'h0C, 8'h06, 8'h17, 8'h36, 8'h2B, 8'h14},
                               '{8'h40, 8'h00, 8'h47, 8'h4F, 8'h0A, 8'h03, 8'h39, 8'h06},
                               '{8'h40, 8'h00, 8'h0C, 8'h1C, 8'h0A, 8'h03, 8'h1B, 8'h06}};
    logic [15:0] seed [2] = '{16'h5A3C, 16'hC681};
    logic [7:0] exp;
    for (int b = 0; b < 2; b++)
    begin
      @(posedge mclk_i);
      base <= seed[b];
      for (int c = 0; c < 4; c++)
      begin
        wr(REMAP_OFFSET, cfg[c]);
        settle();
        for (int j = 0; j < 8; j++)
          exp[7 - j] = pins[src[c][j][7:4]][src[c][j][3:0]];
        chk({timer34_external_trigger_input_o, timer2_external_trigger_input_o,
             timer1_external_trigger_input_o, timer1_break_input_o, serial1_rx_o, serial2_rx_o,
             serial3_rx_o, spi_port1_miso_o}, exp);
      end
    end
  endtask

  task automatic irq_select;
    logic [15:0] val;
    logic [IRQ_LINES-1:0] exp;
    for (int p = 0; p < 7; p++)
    begin
      for (int r = 0; r < 3; r++)
      begin
        for (int i = 0; i < 4; i++)
          val[4 * i +: 4] = 4'((p + i + r) % 7);
        wr(5'(IRQ_SEL_0_3_OFFSET + 5'(4 * r)), {16'hFFFF, val});
        rd(5'(IRQ_SEL_0_3_OFFSET + 5'(4 * r)), {16'h0, val});
      end
      settle();
      for (int n = 0; n < IRQ_LINES; n++)
        exp[n] = pins[(p + n % 4 + n / 4) % 7][n];
      chk(ext_irq_line_source_o, exp);
    end
    // Selector codes past port G are kept but drive their lines low.
    wr(IRQ_SEL_0_3_OFFSET, 32'h0000987F);
    rd(IRQ_SEL_0_3_OFFSET, 32'h0000987F);
    settle();
    exp[3:0] = 4'h0;
    chk(ext_irq_line_source_o, exp);
  endtask

  initial
  begin
    rstn_i = 1'b0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 5'h0;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'hF;
    base = 16'h5A3C;
    repeat (16) @(posedge mclk_i);
    rstn_i <= 1'b1;
    reset_vals();
    remap_fields();
    debug_codes();
    pin_mux();
    irq_select();
    summarize();
  end
endmodule // testbench
